// [scr_clock_control_regs.sv]
// Clock and alignment reference control registers with the capture position status.
module scr_clock_control_regs (
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Register access from the serial interface framing.
  input  wire logic                           reg_wr_en,
  input  wire logic                           reg_rd_en,
  input  wire logic [scr_pkg::SCR_ADDR_W-1:0] reg_addr,
  input  wire logic [scr_pkg::SCR_DATA_W-1:0] reg_wr_data,
  output logic      [scr_pkg::SCR_DATA_W-1:0] reg_rd_data,
  output logic                                reg_rd_valid,
  // Alignment reference path.
  input  wire logic                           ref_in,
  input  wire logic [scr_pkg::SCR_POS_W-1:0]  edge_pos_in,
  output logic                                ref_aligned,
  // Controls to the analog front end and windowing logic.
  output scr_pkg::scr_ctrl_s                  ctrl
);
  import scr_pkg::*;

  logic [SCR_DATA_W-1:0] clock_control_0_r;
  logic [SCR_DATA_W-1:0] clock_control_1_r;
  logic [SCR_DATA_W-1:0] clock_control_2_r;
  logic [SCR_POS_W-1:0]  ref_edge_position_status_r;
  logic [SCR_POS_W-1:0]  ref_edge_position_status_nxt;
  logic [SCR_DATA_W-1:0] rd_data_r;
  logic [SCR_DATA_W-1:0] rd_data_nxt;
  logic                  rd_valid_r;
  logic                  ref_aligned_r;
  logic                  ref_aligned_nxt;

  // Address decode of the bank.
  wire logic hit_ctrl0 = (reg_addr == SCR_CTRL0_ADDR);
  wire logic hit_ctrl1 = (reg_addr == SCR_CTRL1_ADDR);
  wire logic hit_ctrl2 = (reg_addr == SCR_CTRL2_ADDR);
  wire logic hit_pos0  = (reg_addr == SCR_POS0_ADDR);
  wire logic hit_pos1  = (reg_addr == SCR_POS1_ADDR);
  wire logic hit_pos2  = (reg_addr == SCR_POS2_ADDR);
  wire logic wr_ctrl0  = reg_wr_en & hit_ctrl0;
  wire logic wr_ctrl1  = reg_wr_en & hit_ctrl1;
  wire logic wr_ctrl2  = reg_wr_en & hit_ctrl2;

  // Writable control registers; reserved bits are stored as written so readback is honest.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_control_0_r <= SCR_CTRL0_RST;
      clock_control_1_r <= SCR_CTRL1_RST;
      clock_control_2_r <= SCR_CTRL2_RST;
    end else begin
      if (wr_ctrl0) clock_control_0_r <= reg_wr_data;
      if (wr_ctrl1) clock_control_1_r <= reg_wr_data;
      if (wr_ctrl2) clock_control_2_r <= reg_wr_data;
    end
  end

  // The position status follows the detector only while the receiver is powered, so the
  // last capture stays readable after the receiver is shut down. Bus writes never reach it.
  assign ref_edge_position_status_nxt = clock_control_0_r[SCR_RECV_EN_BIT] ? edge_pos_in
                                        : ref_edge_position_status_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ref_edge_position_status_r <= SCR_POS_RST;
    else        ref_edge_position_status_r <= ref_edge_position_status_nxt;
  end

  // Read multiplexer; unmapped addresses read as zero.
  assign rd_data_nxt = hit_ctrl0 ? clock_control_0_r :
                       hit_ctrl1 ? clock_control_1_r :
                       hit_ctrl2 ? clock_control_2_r :
                       hit_pos0  ? ref_edge_position_status_r[7:0] :
                       hit_pos1  ? ref_edge_position_status_r[15:8] :
                       hit_pos2  ? ref_edge_position_status_r[23:16] : SCR_RD_ZERO;

  // Read data is registered and held until the next read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r  <= SCR_RD_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) rd_data_r <= rd_data_nxt;
    end
  end

  // Reference events pass only when the processor is enabled; the receiver bit also gates
  // them, since an unpowered receiver delivers no meaningful level even if the host ordered
  // the enables wrongly.
  assign ref_aligned_nxt = (ref_in ^ clock_control_1_r[SCR_INVERT_BIT])
                         & clock_control_0_r[SCR_PROC_EN_BIT]
                         & clock_control_0_r[SCR_RECV_EN_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ref_aligned_r <= 1'b0;
    else        ref_aligned_r <= ref_aligned_nxt;
  end

  // Control outputs are plain slices of the flops above.
  assign ctrl.ref_event_processor_enable = clock_control_0_r[SCR_PROC_EN_BIT];
  assign ctrl.ref_receiver_enable        = clock_control_0_r[SCR_RECV_EN_BIT];
  assign ctrl.fine_window_scale          = clock_control_0_r[SCR_ZOOM_BIT];
  assign ctrl.ref_delay_select = clock_control_0_r[SCR_SEL_MSB:SCR_SEL_LSB];
  assign ctrl.ref_polarity_invert        = clock_control_1_r[SCR_INVERT_BIT];
  assign ctrl.clock_input_pecl_mode      = clock_control_1_r[SCR_CLK_PECL_BIT];
  assign ctrl.ref_input_pecl_mode        = clock_control_1_r[SCR_REF_PECL_BIT];
  assign ctrl.analog_rail_noise_suppress = clock_control_2_r[SCR_ANA_NS_BIT];
  assign ctrl.clock_rail_noise_suppress  = clock_control_2_r[SCR_CLK_NS_BIT];
  assign reg_rd_data                     = rd_data_r;
  assign reg_rd_valid                    = rd_valid_r;
  assign ref_aligned                     = ref_aligned_r;

  // Checks on the bank.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_wr0;
    reg_wr_en && (reg_addr == SCR_CTRL0_ADDR);
  endsequence

  sequence seq_wr1;
    reg_wr_en && (reg_addr == SCR_CTRL1_ADDR);
  endsequence

  sequence seq_wr2;
    reg_wr_en && (reg_addr == SCR_CTRL2_ADDR);
  endsequence

  sequence seq_path_open;
    ctrl.ref_event_processor_enable && ctrl.ref_receiver_enable;
  endsequence

  chk_ctrl0_reset_value: assert property (
    $rose(rst_n) |-> (clock_control_0_r == SCR_CTRL0_RST))
    else $error("Clock control 0 did not hold its reset value.");

  chk_proc_gate_event: assert property (
    ref_aligned |-> $past(ctrl.ref_event_processor_enable))
    else $error("Reference event passed while the processor was disabled.");

  chk_recv_power_follow: assert property (
    seq_wr0 |=> ctrl.ref_receiver_enable == $past(reg_wr_data[SCR_RECV_EN_BIT]))
    else $error("Receiver enable did not follow the written bit.");

  chk_zoom_delay_sel: assert property (
    seq_wr0 |=> (ctrl.fine_window_scale == $past(reg_wr_data[SCR_ZOOM_BIT]))
            && (ctrl.ref_delay_select == $past(reg_wr_data[SCR_SEL_MSB:SCR_SEL_LSB])))
    else $error("Zoom or delay select did not take the written value.");

  chk_polarity_invert: assert property (
    seq_path_open ##1 seq_path_open |->
      ref_aligned == ($past(ref_in) ^ $past(ctrl.ref_polarity_invert)))
    else $error("Aligned reference has the wrong polarity.");

  chk_pecl_modes: assert property (
    seq_wr1 |=> (ctrl.clock_input_pecl_mode == $past(reg_wr_data[SCR_CLK_PECL_BIT]))
            && (ctrl.ref_input_pecl_mode == $past(reg_wr_data[SCR_REF_PECL_BIT])))
    else $error("Input PECL mode did not follow the written bits.");

  chk_noise_suppress: assert property (
    seq_wr2 |=> (ctrl.analog_rail_noise_suppress == $past(reg_wr_data[SCR_ANA_NS_BIT]))
            && (ctrl.clock_rail_noise_suppress == $past(reg_wr_data[SCR_CLK_NS_BIT])))
    else $error("Rail noise suppression did not follow the written bits.");

  chk_pos_write_ignored: assert property (
    (ref_edge_position_status_r != $past(ref_edge_position_status_r)) |->
      (ref_edge_position_status_r == $past(edge_pos_in)) && $past(ctrl.ref_receiver_enable))
    else $error("Position status changed from a source other than the detector.");

  chk_pos_read_bytes: assert property (
    reg_rd_en && (reg_addr == SCR_POS2_ADDR) |=>
      reg_rd_valid && (reg_rd_data == $past(ref_edge_position_status_r[23:16])))
    else $error("Position top byte read back wrongly.");

  // Read strobes for each mapped address except the top position byte; the answer shows one edge later.
  sequence seq_rd0;
    reg_rd_en && (reg_addr == SCR_CTRL0_ADDR);
  endsequence

  sequence seq_rd1;
    reg_rd_en && (reg_addr == SCR_CTRL1_ADDR);
  endsequence

  sequence seq_rd2;
    reg_rd_en && (reg_addr == SCR_CTRL2_ADDR);
  endsequence

  sequence seq_rd_pos0;
    reg_rd_en && (reg_addr == SCR_POS0_ADDR);
  endsequence

  sequence seq_rd_pos1;
    reg_rd_en && (reg_addr == SCR_POS1_ADDR);
  endsequence

  // Readback checks compare against the stored image, so a read that lands together with a
  // write must still return the old byte, as the host expects.
  chk_ctrl0_readback: assert property (
    seq_rd0 |=> reg_rd_valid && (reg_rd_data == $past(clock_control_0_r)))
    else $error("Clock control 0 read back wrongly.");

  chk_ctrl1_readback: assert property (
    seq_rd1 |=> reg_rd_valid && (reg_rd_data == $past(clock_control_1_r)))
    else $error("Clock control 1 read back wrongly.");

  chk_ctrl2_readback: assert property (
    seq_rd2 |=> reg_rd_valid && (reg_rd_data == $past(clock_control_2_r)))
    else $error("Clock control 2 read back wrongly.");

  chk_pos_low_read: assert property (
    seq_rd_pos0 |=> reg_rd_valid && (reg_rd_data == $past(ref_edge_position_status_r[7:0])))
    else $error("Position low byte read back wrongly.");

  chk_pos_mid_read: assert property (
    seq_rd_pos1 |=> reg_rd_valid && (reg_rd_data == $past(ref_edge_position_status_r[15:8])))
    else $error("Position middle byte read back wrongly.");

  chk_unmapped_read_zero: assert property (
    reg_rd_en && !(hit_ctrl0 || hit_ctrl1 || hit_ctrl2 || hit_pos0 || hit_pos1 || hit_pos2)
      |=> reg_rd_valid && (reg_rd_data == SCR_RD_ZERO))
    else $error("Unmapped address did not read as zero.");

  chk_rd_valid_pulse: assert property (
    reg_rd_en |=> reg_rd_valid)
    else $error("Read valid missing after a read strobe.");

  chk_rd_valid_idle: assert property (
    !reg_rd_en |=> !reg_rd_valid)
    else $error("Read valid raised without a read strobe.");

  chk_rd_data_hold: assert property (
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("Read data changed without a read strobe.");

  chk_ctrl0_hold: assert property (
    !wr_ctrl0 |=> $stable(clock_control_0_r))
    else $error("Clock control 0 changed without a write.");

  chk_ctrl1_hold: assert property (
    !wr_ctrl1 |=> $stable(clock_control_1_r))
    else $error("Clock control 1 changed without a write.");

  chk_ctrl2_hold: assert property (
    !wr_ctrl2 |=> $stable(clock_control_2_r))
    else $error("Clock control 2 changed without a write.");

  chk_ctrl0_reserved_bit: assert property (
    seq_wr0 |=> clock_control_0_r[7] == $past(reg_wr_data[7]))
    else $error("Reserved top bit of clock control 0 not stored as written.");

  chk_ctrl12_reset_value: assert property (
    $rose(rst_n) |-> (clock_control_1_r == SCR_CTRL1_RST)
                  && (clock_control_2_r == SCR_CTRL2_RST))
    else $error("Clock control 1 or 2 did not hold its reset value.");

  chk_recv_gate_event: assert property (
    ref_aligned |-> $past(ctrl.ref_receiver_enable))
    else $error("Reference event passed while the receiver was off.");

  chk_aligned_no_proc: assert property (
    !ctrl.ref_event_processor_enable |=> !ref_aligned)
    else $error("Aligned reference high one cycle after the processor was off.");

  chk_aligned_no_recv: assert property (
    !ctrl.ref_receiver_enable |=> !ref_aligned)
    else $error("Aligned reference high one cycle after the receiver was off.");

  // The status is frozen while the receiver is off, so the host can read a stable capture.
  chk_pos_hold_idle: assert property (
    !ctrl.ref_receiver_enable |=> $stable(ref_edge_position_status_r))
    else $error("Position status moved while the receiver was off.");

  chk_pos_track_live: assert property (
    ctrl.ref_receiver_enable |=> ref_edge_position_status_r == $past(edge_pos_in))
    else $error("Position status did not follow the detector.");

endmodule

// [scr_pkg.sv]
// Package with the register map, reset values and control carrier of the clock control bank.
package scr_pkg;

  // Register port widths.
  localparam int SCR_ADDR_W = 15;
  localparam int SCR_DATA_W = 8;
  localparam int SCR_POS_W  = 24;

  // Byte addresses of the bank; the position status spans three bytes, low byte first.
  localparam logic [SCR_ADDR_W-1:0] SCR_CTRL0_ADDR = 15'h0029;
  localparam logic [SCR_ADDR_W-1:0] SCR_CTRL1_ADDR = 15'h002A;
  localparam logic [SCR_ADDR_W-1:0] SCR_CTRL2_ADDR = 15'h002B;
  localparam logic [SCR_ADDR_W-1:0] SCR_POS0_ADDR  = 15'h002C;
  localparam logic [SCR_ADDR_W-1:0] SCR_POS1_ADDR  = 15'h002D;
  localparam logic [SCR_ADDR_W-1:0] SCR_POS2_ADDR  = 15'h002E;

  // Values after reset.
  localparam logic [SCR_DATA_W-1:0] SCR_CTRL0_RST = 8'h80;
  localparam logic [SCR_DATA_W-1:0] SCR_CTRL1_RST = 8'h00;
  localparam logic [SCR_DATA_W-1:0] SCR_CTRL2_RST = 8'h10;
  localparam logic [SCR_POS_W-1:0]  SCR_POS_RST   = 24'h00_0000;
  localparam logic [SCR_DATA_W-1:0] SCR_RD_ZERO   = 8'h00;

  // Field positions in clock control 0.
  localparam int SCR_PROC_EN_BIT = 6;
  localparam int SCR_RECV_EN_BIT = 5;
  localparam int SCR_ZOOM_BIT    = 4;
  localparam int SCR_SEL_MSB     = 3;
  localparam int SCR_SEL_LSB     = 0;

  // Field positions in clock control 1.
  localparam int SCR_CLK_PECL_BIT = 2;
  localparam int SCR_REF_PECL_BIT = 1;
  localparam int SCR_INVERT_BIT   = 0;

  // Field positions in clock control 2.
  localparam int SCR_ANA_NS_BIT = 2;
  localparam int SCR_CLK_NS_BIT = 0;

  // Controls handed to the analog and windowing logic.
  typedef struct packed {
    logic       ref_event_processor_enable;
    logic       ref_receiver_enable;
    logic       fine_window_scale;
    logic [3:0] ref_delay_select;
    logic       ref_polarity_invert;
    logic       clock_input_pecl_mode;
    logic       ref_input_pecl_mode;
    logic       analog_rail_noise_suppress;
    logic       clock_rail_noise_suppress;
  } scr_ctrl_s;

endpackage

// [scr_host_model.sv]
// Host model that writes and reads the clock control bank one byte at a time.
module scr_host_model (
  // Clock.
  input  wire logic                           clk,
  // Strobes, address and data toward the bank.
  output logic                                reg_wr_en,
  output logic                                reg_rd_en,
  output logic      [scr_pkg::SCR_ADDR_W-1:0] reg_addr,
  output logic      [scr_pkg::SCR_DATA_W-1:0] reg_wr_data,
  // Read answer from the bank.
  input  wire logic [scr_pkg::SCR_DATA_W-1:0] reg_rd_data,
  input  wire logic                           reg_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import scr_pkg::*;
  logic recv_on = 1'b0;
  initial begin
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
    reg_addr    = 15'h0000;
    reg_wr_data = 8'h00;
  end
  // One-cycle strobe; released lines flip so a stale value never looks valid.
  task automatic strobe(input logic wr, input logic [14:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr_en   = wr;
    reg_rd_en   = ~wr;
    reg_addr    = a;
    reg_wr_data = d;
    @(negedge clk);
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
    reg_addr    = ~a;
    reg_wr_data = ~d;
  endtask
  // Writes to clock control 0 keep the reserved top bit; one that enables the processor while the receiver is off first goes out without the processor bit.
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == SCR_CTRL0_ADDR) v[7] = 1'b1;
    if (a == SCR_CTRL0_ADDR && v[6] && !recv_on) strobe(1'b1, a, v & 8'hBF);
    if (a == SCR_CTRL0_ADDR) recv_on = v[5];
    strobe(1'b1, a, v);
  endtask
  // The answer is taken in the cycle after the read strobe.
  task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic v);
    strobe(1'b0, a, reg_wr_data);
    d = reg_rd_data;
    v = reg_rd_valid;
  endtask
endmodule

// [tb_scr_clock_control_regs.sv]
// Self-checking bench for the clock control register bank.
module tb_scr_clock_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import scr_pkg::*;
  logic            clk = 1'b0, rst_n = 1'b0, ref_in = 1'b0, wr_en, rd_en, rd_valid, aligned;
  logic [14:0]     addr;
  logic [7:0]      wdata, rdata, got, c0, c1, c2;
  logic [23:0]     pos_in = 24'h00_0000, pos;
  scr_ctrl_s       ctrl;
  int              failures = 0, n_compared = 0, cycles = 0, seed = 32'h0dfe;
  always #20 clk = ~clk;
  scr_clock_control_regs i_dut (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rd_valid),
    .ref_in(ref_in), .edge_pos_in(pos_in), .ref_aligned(aligned), .ctrl(ctrl));
  scr_host_model i_host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rd_valid));
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected control fields from the three register images.
  function automatic scr_ctrl_s exp_ctrl(logic [7:0] a, logic [7:0] b, logic [7:0] c);
    return '{a[6], a[5], a[4], a[3:0], b[0], b[2], b[1], c[2], c[0]};
  endfunction
  function automatic logic exp_ref(logic r, logic [7:0] a, logic [7:0] b);
    return (r ^ b[0]) & a[6] & a[5];
  endfunction
  task automatic rd_chk(input string what, input logic [14:0] a, input logic [7:0] exp);
    logic v;
    i_host.rd(a, got, v);
    chk("read valid", 24'(v), 24'h00_0001);
    chk(what, 24'(got), 24'(exp));
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang costs a mismatch instead of an endless run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk("ctrl reset", 24'(ctrl), 24'h00_0000);
    rd_chk("ctrl0 reset", SCR_CTRL0_ADDR, SCR_CTRL0_RST);
    rd_chk("ctrl1 reset", SCR_CTRL1_ADDR, SCR_CTRL1_RST);
    rd_chk("ctrl2 reset", SCR_CTRL2_ADDR, SCR_CTRL2_RST);
    rd_chk("unmapped", 15'h0040, SCR_RD_ZERO);
    $display("test reset done");
    // Random settings; reserved bits stay at reset values, processor only with receiver.
    for (int i = 0; i < 40; i++) begin
      c0 = 8'h80 | 8'($random(seed));
      c0[5] = c0[5] | c0[6];
      c1 = 8'($random(seed)) & 8'h07;
      c2 = 8'h10 | (8'($random(seed)) & 8'h05);
      i_host.wr(SCR_CTRL0_ADDR, c0);
      i_host.wr(SCR_CTRL1_ADDR, c1);
      i_host.wr(SCR_CTRL2_ADDR, c2);
      chk("ctrl", 24'(ctrl), 24'(exp_ctrl(c0, c1, c2)));
      rd_chk("ctrl0", SCR_CTRL0_ADDR, c0);
      rd_chk("ctrl2", SCR_CTRL2_ADDR, c2);
      repeat (4) begin
        ref_in = 1'($random(seed));
        @(negedge clk);
        chk("aligned", 24'(aligned), 24'(exp_ref(ref_in, c0, c1)));
      end
    end
    $display("test control done");
    // Position tracks while the receiver runs, ignores writes, holds once it stops.
    i_host.wr(SCR_CTRL0_ADDR, 8'hA0);
    pos_in = 24'($random(seed));
    i_host.wr(SCR_CTRL0_ADDR, 8'h80);
    pos = pos_in;
    // Writes land while the status is frozen, so a leak would survive to the readback.
    i_host.wr(SCR_POS0_ADDR, ~pos_in[7:0]);
    i_host.wr(SCR_POS2_ADDR, ~pos_in[23:16]);
    pos_in = ~pos_in;
    rd_chk("pos low", SCR_POS0_ADDR, pos[7:0]);
    rd_chk("pos mid", SCR_POS1_ADDR, pos[15:8]);
    rd_chk("pos high", SCR_POS2_ADDR, pos[23:16]);
    // Delay picked from the captured low position byte, with zoom on as a fast clock would want.
    i_host.wr(SCR_CTRL0_ADDR, {4'h9, pos[3:0]});
    chk("delay from pos", 24'(ctrl.ref_delay_select), 24'(pos[3:0]));
    chk("zoom on", 24'(ctrl.fine_window_scale), 24'h00_0001);
    rd_chk("ctrl1 last", SCR_CTRL1_ADDR, c1);
    $display("test position done");
    complete_run();
  end
endmodule
